//--- rtl/iop_pkg.sv
/*
 Package for the port pin interrupt and pin configuration block.
 Holds register offsets, field layouts, reset values, drive codes and carriers.
 Assumes a classic Wishbone master with 32-bit data and byte addresses.
*/
package iop_pkg;

	localparam int NPIN = 8;
	localparam int NPAIR = NPIN / 2;

	// Register byte offsets
	localparam logic [7:0] OFS_DATA     = 8'h00;
	localparam logic [7:0] OFS_DRIVE    = 8'h04;
	localparam logic [7:0] OFS_SLEW     = 8'h08;
	localparam logic [7:0] OFS_INDIS    = 8'h0C;
	localparam logic [7:0] OFS_PORTCFG  = 8'h10;
	localparam logic [7:0] OFS_EDGE     = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_REGSEL   = 8'h1C;
	localparam logic [7:0] OFS_PAIRREF  = 8'h20;
	localparam logic [7:0] OFS_PINSTATE = 8'h24;
	localparam logic [7:0] OFS_IRQEN    = 8'h28;
	localparam logic [7:0] OFS_IRQCLR   = 8'h2C;
	localparam logic [7:0] OFS_RAWSTAT  = 8'h30;

	// Port config fields
	localparam int PC_LVTTL = 0;
	localparam int PC_RSTCFG_LSB = 1;

	// Pair reference fields: 2-bit threshold, analog bit, hysteresis bit
	localparam int PR_W = 4;
	localparam int PR_ANALOG = 2;
	localparam int PR_HYST = 3;

	typedef enum logic [1:0] {
		IOP_EDGE_NONE = 2'b00,
		IOP_EDGE_RISE = 2'b01,
		IOP_EDGE_FALL = 2'b10,
		IOP_EDGE_BOTH = 2'b11
	} iop_edge_e;

	typedef enum logic [1:0] {
		IOP_THR_HALF_VIO = 2'b00,
		IOP_THR_04_VIO   = 2'b01,
		IOP_THR_HALF_REF = 2'b10,
		IOP_THR_REF      = 2'b11
	} iop_thr_e;

	// Drive codes
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIG    = 3'h1;
	localparam logic [2:0] DM_RES_UP     = 3'h2;
	localparam logic [2:0] DM_RES_DN     = 3'h3;
	localparam logic [2:0] DM_OD_LO      = 3'h4;
	localparam logic [2:0] DM_OD_HI      = 3'h5;
	localparam logic [2:0] DM_STRONG     = 3'h6;
	localparam logic [2:0] DM_RES_BOTH   = 3'h7;

	// Reset configuration codes
	localparam logic [1:0] RC_HIZ  = 2'h0;
	localparam logic [1:0] RC_PDN  = 2'h1;
	localparam logic [1:0] RC_PUP  = 2'h2;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// Per-pin analog control toward the pad
	typedef struct packed {
		logic       drv_en;
		logic       drv_val;
		logic       res_en;
		logic       slow;
		logic       in_en;
		logic       reg_hi;
	} iop_pad_s;

	// Per-pair reference control
	typedef struct packed {
		logic [1:0] thr;
		logic       analog;
		logic       hyst;
	} iop_ref_s;

endpackage

//--- rtl/iop_port.sv
/*
 Port pin interrupt unit and pin configuration for one eight-pin port.
 Assumes a classic Wishbone master on clk_i, an asynchronous pin bus in,
 and analog pad cells that take the per-pin and per-pair controls out.
*/
`timescale 1ns/1ns
module iop_port #(
	parameter int NPIN = iop_pkg::NPIN
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic [7:0]              adr_i,
	input  wire logic [31:0]             dat_i,
	output logic      [31:0]             dat_o,
	input  wire logic                    we_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	output logic                         ack_o,
	output logic                         err_o,
	input  wire logic [1:0]              nv_rstcfg_i,
	input  wire logic [NPIN-1:0]         pin_i,
	output logic      [NPIN-1:0]         pin_o,
	output logic      [NPIN-1:0]         pin_oe_o,
	output iop_pkg::iop_pad_s [NPIN-1:0] pad_o,
	output iop_pkg::iop_ref_s [NPIN/2-1:0] ref_o,
	output logic                         lvttl_o,
	output logic                         irq_o
);

	// Decode and register layout are fixed to one eight-pin port
	if (NPIN != 8)
	begin : g_bad_width
		$error("Port width must be eight pins");
	end

	localparam int NP = NPIN / 2;

	// Configuration state
	logic [NPIN-1:0]   data_reg, data_next;
	logic [3*NPIN-1:0] drive_reg, drive_next;
	logic [NPIN-1:0]   slew_reg, slew_next;
	logic [NPIN-1:0]   indis_reg, indis_next;
	logic [2:0]        portcfg_reg, portcfg_next;
	logic [2*NPIN-1:0] edge_reg, edge_next;
	logic [NPIN-1:0]   regsel_reg, regsel_next;
	logic [4*NP-1:0]   pairref_reg, pairref_next;
	logic [NPIN-1:0]   irqen_reg, irqen_next;
	logic [NPIN-1:0]   stat_reg, stat_next;
	logic              ack_reg, ack_next;
	logic              err_reg, err_next;
	logic [31:0]       rdat_reg, rdat_next;
	logic              rstld_reg, rstld_next;

	// Synchroniser and edge history
	logic [NPIN-1:0] sync1_reg, sync2_reg, prev_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end
		else
		begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Edge detect only; levels never set status, and no sleep gating exists
	logic [NPIN-1:0] evt;
	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_edge
			logic rise, fall;
			assign rise = sync2_reg[g] & ~prev_reg[g];
			assign fall = ~sync2_reg[g] & prev_reg[g];
			assign evt[g] = (edge_reg[2*g] & rise) | (edge_reg[2*g+1] & fall);
		end
	endgenerate

	function automatic logic [31:0] wmask(input logic [3:0] s);
		wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= iop_pkg::OFS_RAWSTAT);
	endfunction

	logic        req;
	logic        wr;
	logic        rd;
	logic [31:0] m;
	logic [31:0] wv;

	assign req = cyc_i & stb_i & ~ack_reg & ~err_reg;
	assign wr  = req & we_i & mapped(adr_i);
	assign rd  = req & ~we_i & mapped(adr_i);
	assign m   = wmask(sel_i);

	always_comb
	begin
		data_next    = data_reg;
		drive_next   = drive_reg;
		slew_next    = slew_reg;
		indis_next   = indis_reg;
		portcfg_next = portcfg_reg;
		edge_next    = edge_reg;
		regsel_next  = regsel_reg;
		pairref_next = pairref_reg;
		irqen_next   = irqen_reg;
		stat_next    = stat_reg;
		rdat_next    = rdat_reg;
		rstld_next   = 1'b0;
		ack_next     = req & mapped(adr_i);
		err_next     = req & ~mapped(adr_i);
		wv           = dat_i & m;

		// Load of stored reset configuration one cycle after release
		if (rstld_reg)
		begin
			portcfg_next[2:1] = nv_rstcfg_i;
			for (int i = 0; i < NPIN; i++)
			begin
				case (nv_rstcfg_i)
					iop_pkg::RC_PDN: begin drive_next[3*i +: 3] = iop_pkg::DM_RES_DN; data_next[i] = 1'b0; end
					iop_pkg::RC_PUP: begin drive_next[3*i +: 3] = iop_pkg::DM_RES_UP; data_next[i] = 1'b1; end
					default: drive_next[3*i +: 3] = iop_pkg::DM_HIZ_ANALOG;
				endcase
			end
		end

		if (wr)
		begin
			case (adr_i)
				iop_pkg::OFS_DATA:    data_next    = (data_reg & ~m[NPIN-1:0]) | wv[NPIN-1:0];
				iop_pkg::OFS_DRIVE:   drive_next   = (drive_reg & ~m[3*NPIN-1:0]) | wv[3*NPIN-1:0];
				iop_pkg::OFS_SLEW:    slew_next    = (slew_reg & ~m[NPIN-1:0]) | wv[NPIN-1:0];
				iop_pkg::OFS_INDIS:   indis_next   = (indis_reg & ~m[NPIN-1:0]) | wv[NPIN-1:0];
				iop_pkg::OFS_PORTCFG: portcfg_next = (portcfg_reg & ~m[2:0]) | wv[2:0];
				iop_pkg::OFS_EDGE:    edge_next    = (edge_reg & ~m[2*NPIN-1:0]) | wv[2*NPIN-1:0];
				iop_pkg::OFS_REGSEL:  regsel_next  = (regsel_reg & ~m[NPIN-1:0]) | wv[NPIN-1:0];
				iop_pkg::OFS_PAIRREF: pairref_next = (pairref_reg & ~m[4*NP-1:0]) | wv[4*NP-1:0];
				iop_pkg::OFS_IRQEN:   irqen_next   = (irqen_reg & ~m[NPIN-1:0]) | wv[NPIN-1:0];
				iop_pkg::OFS_IRQCLR:  stat_next    = stat_reg & ~wv[NPIN-1:0];
				default: ;
			endcase
		end

		// Read of the status register clears it
		if (rd && adr_i == iop_pkg::OFS_STATUS)
			stat_next = '0;
		// Set wins over any clear in the same cycle
		stat_next = stat_next | evt;

		rdat_next = '0;
		if (rd)
		begin
			case (adr_i)
				iop_pkg::OFS_DATA:     rdat_next[NPIN-1:0]   = data_reg;
				iop_pkg::OFS_DRIVE:    rdat_next[3*NPIN-1:0] = drive_reg;
				iop_pkg::OFS_SLEW:     rdat_next[NPIN-1:0]   = slew_reg;
				iop_pkg::OFS_INDIS:    rdat_next[NPIN-1:0]   = indis_reg;
				iop_pkg::OFS_PORTCFG:  rdat_next[2:0]        = portcfg_reg;
				iop_pkg::OFS_EDGE:     rdat_next[2*NPIN-1:0] = edge_reg;
				iop_pkg::OFS_STATUS:   rdat_next[NPIN-1:0]   = stat_reg;
				iop_pkg::OFS_REGSEL:   rdat_next[NPIN-1:0]   = regsel_reg;
				iop_pkg::OFS_PAIRREF:  rdat_next[4*NP-1:0]   = pairref_reg;
				iop_pkg::OFS_PINSTATE: rdat_next[NPIN-1:0]   = sync2_reg & ~indis_reg;
				iop_pkg::OFS_IRQEN:    rdat_next[NPIN-1:0]   = irqen_reg;
				iop_pkg::OFS_RAWSTAT:  rdat_next[NPIN-1:0]   = stat_reg;
				default:               rdat_next             = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			data_reg    <= '0;
			drive_reg   <= '0;
			slew_reg    <= '0;
			indis_reg   <= '0;
			portcfg_reg <= '0;
			edge_reg    <= '0;
			regsel_reg  <= '0;
			pairref_reg <= '0;
			irqen_reg   <= '1;
			stat_reg    <= '0;
			ack_reg     <= 1'b0;
			err_reg     <= 1'b0;
			rdat_reg    <= iop_pkg::RST_ZERO;
			rstld_reg   <= 1'b1;
		end
		else
		begin
			// No low-power gating: state only changes by bus, reset or pin edges
			data_reg    <= data_next;
			drive_reg   <= drive_next;
			slew_reg    <= slew_next;
			indis_reg   <= indis_next;
			portcfg_reg <= portcfg_next;
			edge_reg    <= edge_next;
			regsel_reg  <= regsel_next;
			pairref_reg <= pairref_next;
			irqen_reg   <= irqen_next;
			stat_reg    <= stat_next;
			ack_reg     <= ack_next;
			err_reg     <= err_next;
			rdat_reg    <= rdat_next;
			rstld_reg   <= rstld_next;
		end
	end

	assign ack_o   = ack_reg;
	assign err_o   = err_reg;
	assign dat_o   = rdat_reg;
	assign irq_o   = |(stat_reg & irqen_reg);
	assign lvttl_o = portcfg_reg[iop_pkg::PC_LVTTL];

	// Pad decode per pin
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_pad
			logic [2:0] dm;
			logic       d;
			logic       res_mode;
			logic       hi_drv, lo_drv, hi_res, lo_res;
			assign dm = rst_i ? iop_pkg::DM_HIZ_ANALOG : drive_reg[3*g +: 3];
			assign d  = data_reg[g];
			// Resistive modes fall back to strong while regulated output is on
			assign res_mode = (dm == iop_pkg::DM_RES_UP) | (dm == iop_pkg::DM_RES_DN) |
				(dm == iop_pkg::DM_RES_BOTH);
			assign hi_drv = d & ((dm == iop_pkg::DM_RES_DN) | (dm == iop_pkg::DM_OD_HI) |
				(dm == iop_pkg::DM_STRONG));
			assign lo_drv = ~d & ((dm == iop_pkg::DM_RES_UP) | (dm == iop_pkg::DM_OD_LO) |
				(dm == iop_pkg::DM_STRONG));
			assign hi_res = d & ((dm == iop_pkg::DM_RES_UP) | (dm == iop_pkg::DM_RES_BOTH));
			assign lo_res = ~d & ((dm == iop_pkg::DM_RES_DN) | (dm == iop_pkg::DM_RES_BOTH));
			assign pin_oe_o[g] = hi_drv | lo_drv | (regsel_reg[g] & (hi_res | lo_res)) |
				(~regsel_reg[g] & (hi_res | lo_res));
			assign pin_o[g] = d;
			assign pad_o[g].drv_en  = hi_drv | lo_drv | (regsel_reg[g] & (hi_res | lo_res));
			assign pad_o[g].drv_val = d;
			assign pad_o[g].res_en  = ~regsel_reg[g] & (hi_res | lo_res);
			assign pad_o[g].slow    = slew_reg[g] & ~res_mode;
			assign pad_o[g].in_en   = (dm != iop_pkg::DM_HIZ_ANALOG) & ~indis_reg[g];
			assign pad_o[g].reg_hi  = regsel_reg[g];
		end
		for (g = 0; g < NP; g++)
		begin : g_ref
			assign ref_o[g].thr    = pairref_reg[4*g +: 2];
			assign ref_o[g].analog = pairref_reg[4*g + iop_pkg::PR_ANALOG];
			assign ref_o[g].hyst   = pairref_reg[4*g + iop_pkg::PR_HYST];
		end
	endgenerate

	AST_RISE_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		(edge_reg[0] && sync2_reg[0] && !prev_reg[0]) |=> stat_reg[0])
		else $error("Rising edge did not set status");
	AST_NO_EDGE_NO_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		(!stat_reg[1] && !evt[1]) |=> !stat_reg[1])
		else $error("Status set without an edge");
	AST_FALL_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		(edge_reg[3] && !sync2_reg[1] && prev_reg[1]) |=> stat_reg[1])
		else $error("Falling edge did not set status");
	AST_IRQ_TRACKS: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == |(stat_reg & irqen_reg))
		else $error("Request does not follow status");
	AST_READ_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd && adr_i == iop_pkg::OFS_STATUS && evt == '0) |=> stat_reg == '0)
		else $error("Status read did not clear");
	AST_SYNC_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sync2_reg[2]) |-> $past(sync1_reg[2]))
		else $error("Synchroniser order broken");
	AST_RESET_HIZ: assert property (@(posedge clk_i)
		rst_i |-> (pin_oe_o == '0 && !pad_o[0].in_en))
		else $error("Pins not high impedance in reset");
	AST_SLEW_RES: assert property (@(posedge clk_i) disable iff (rst_i)
		(drive_reg[5:3] == iop_pkg::DM_RES_BOTH) |-> !pad_o[1].slow)
		else $error("Slew applied in resistive mode");
	AST_REG_NO_RES: assert property (@(posedge clk_i) disable iff (rst_i)
		regsel_reg[2] |-> !pad_o[2].res_en)
		else $error("Resistive drive while regulated");
	AST_INDIS: assert property (@(posedge clk_i) disable iff (rst_i)
		indis_reg[3] |-> !pad_o[3].in_en)
		else $error("Input buffer not disabled");
	AST_RSTLOAD: assert property (@(posedge clk_i)
		$fell(rst_i) |=> portcfg_reg[2:1] == $past(nv_rstcfg_i))
		else $error("Reset configuration not loaded");
	AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("Ack held two cycles");

endmodule

//--- test/iop_pin_model.sv
/*
 Pin-side partner: external drivers on the eight port pins.
 Assumes pin_oe_o marks the pins that the block itself drives.
*/
`timescale 1ns/1ns
module iop_pin_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] ext_val_i,
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe_o,
	output logic      [7:0] pin_i
);
	logic [7:0] float_reg = 8'h00;
	// Undriven pins toggle so a stale level never looks valid
	always @(posedge clk_i)
		float_reg <= ~float_reg;
	always_comb
		for (int i = 0; i < 8; i++)
			pin_i[i] = pin_oe_o[i] ? pin_o[i] : (ext_en_i[i] ? ext_val_i[i] : float_reg[i]);
endmodule

//--- test/iop_port_tb_top.sv
/*
 Self-checking bench for the port block: register table, edges, interrupt, reset load.
 Assumes the pin partner model and a single 20 MHz clock.
*/
`timescale 1ns/1ns
module iop_port_tb_top;
	logic                    clk_i       = 1'b0;
	logic                    rst_i       = 1'b1;
	logic [7:0]              adr_i       = 8'h00;
	logic [31:0]             dat_i       = 32'h0000_0000;
	logic                    we_i        = 1'b0;
	logic [3:0]              sel_i       = 4'h0;
	logic                    cyc_i       = 1'b0;
	logic                    stb_i       = 1'b0;
	logic [1:0]              nv_rstcfg_i = 2'h0;
	logic [7:0]              ext_val     = 8'h00;
	logic [7:0]              ext_en      = 8'hFF;
	logic [31:0]             dat_o;
	logic                    ack_o;
	logic                    err_o;
	logic                    lvttl_o;
	logic                    irq_o;
	logic [7:0]              pin_i;
	logic [7:0]              pin_o;
	logic [7:0]              pin_oe_o;
	logic [7:0]              in_en_v;
	iop_pkg::iop_pad_s [7:0] pad_o;
	iop_pkg::iop_ref_s [3:0] ref_o;
	logic [31:0]             rd;
	logic                    e;
	int                      num_errors = 0;
	int                      cmp_count  = 0;
	// Rows: address, value written, value read back
	logic [7:0]  t_adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h28};
	logic [31:0] t_val [9] = '{32'h96, 32'hFA_C688, 32'hA5, 32'h3C, 32'h1, 32'hE4E4, 32'h0F, 32'hC6A5, 32'h5A};
	logic [15:0] e_cfg [5] = '{16'h0000, 16'h5555, 16'hAAAA, 16'hFFFF, 16'hE4E4};
	logic [7:0]  e_rise [5] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hAA};
	logic [7:0]  e_fall [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hCC};

	initial
		forever #25 clk_i = ~clk_i;

	iop_port DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
		.sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .nv_rstcfg_i(nv_rstcfg_i),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pad_o(pad_o), .ref_o(ref_o), .lvttl_o(lvttl_o),
		.irq_o(irq_o));
	iop_pin_model u_pins (.clk_i(clk_i), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .pin_i(pin_i));

	always_comb
		for (int i = 0; i < 8; i++)
			in_en_v[i] = pad_o[i].in_en;

	task give_verdict();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// Holds the request until ack or err is sampled high, for at most 20 cycles
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd = dat_o;
		e = err_o;
		chk({31'h0, ack_o | err_o}, 32'h1, "bus answer");
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		wb(1'b0, a, 32'h0);
		chk(rd, exp, msg);
	endtask

	task do_reset(input logic [1:0] nv);
		@(posedge clk_i);
		nv_rstcfg_i <= nv;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk({24'h0, pin_oe_o}, 32'h0, "oe in reset");
		chk({24'h0, in_en_v}, 32'h0, "input in reset");
		@(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict();
	end

	initial
	begin
		do_reset(2'h0);
		rchk(8'h04, 32'h0, "drive after reset");
		rchk(8'h28, 32'hFF, "enable after reset");
		$display("test reset done");
		for (int r = 0; r < 9; r++)
		begin
			wb(1'b1, t_adr[r], t_val[r]);
			rchk(t_adr[r], t_val[r], "readback");
		end
		@(negedge clk_i);
		chk({31'h0, lvttl_o}, 32'h1, "threshold");
		chk({24'h0, pin_o}, {24'h0, t_val[0][7:0]}, "pin out");
		for (int p = 0; p < 4; p++)
			chk({28'h0, ref_o[p]}, {28'h0, t_val[7][4*p+:2], t_val[7][4*p+2], t_val[7][4*p+3]}, "pair");
		for (int i = 0; i < 8; i++)
			chk({31'h0, pad_o[i].reg_hi}, {31'h0, t_val[6][i]}, "reg hi");
		chk({28'h0, pad_o[7].slow, pad_o[6].slow, pad_o[5].slow, pad_o[4].slow}, 32'h2, "slew");
		chk({29'h0, pad_o[3].drv_en, pad_o[3].res_en, pad_o[7].res_en}, 32'h5, "regulated");
		chk({24'h0, in_en_v & 8'h27}, 32'h2, "input off");
		$display("test table done");
		// Every pin in high impedance digital so edges come from outside
		wb(1'b1, 8'h04, 32'h0024_9249);
		wb(1'b1, 8'h0C, 32'h0);
		wb(1'b1, 8'h28, 32'hFF);
		for (int k = 0; k < 5; k++)
		begin
			wb(1'b1, 8'h14, {16'h0, e_cfg[k]});
			wb(1'b0, 8'h18, 32'h0);
			ext_val <= 8'hFF;
			repeat (5) @(posedge clk_i);
			rchk(8'h30, {24'h0, e_rise[k]}, "rise raw");
			chk({31'h0, irq_o}, {31'h0, |e_rise[k]}, "irq rise");
			rchk(8'h24, 32'hFF, "pin state");
			rchk(8'h18, {24'h0, e_rise[k]}, "rise status");
			rchk(8'h30, 32'h0, "held level");
			ext_val <= 8'h00;
			repeat (5) @(posedge clk_i);
			rchk(8'h18, {24'h0, e_fall[k]}, "fall status");
		end
		$display("test edges done");
		wb(1'b1, 8'h28, 32'h02);
		wb(1'b1, 8'h14, 32'h5555);
		ext_val <= 8'h01;
		repeat (5) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0, "masked");
		ext_val <= 8'h03;
		repeat (5) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1, "enabled");
		wb(1'b1, 8'h18, 32'h0);
		wb(1'b1, 8'h2C, 32'h02);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0, "cleared");
		rchk(8'h30, 32'h01, "one bit left");
		rchk(8'h2C, 32'h0, "clear reads zero");
		wb(1'b1, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped");
		wb(1'b0, 8'h05, 32'h0);
		chk({31'h0, e}, 32'h1, "unaligned");
		$display("test irq done");
		wb(1'b1, 8'h04, 32'h00DB_6DB6);
		ext_en <= 8'h00;
		do_reset(2'h1);
		rchk(8'h04, 32'h006D_B6DB, "pull-down codes");
		rchk(8'h00, 32'h0, "pull-down data");
		rchk(8'h10, 32'h2, "stored cfg");
		chk({24'h0, pin_oe_o}, 32'hFF, "pulled");
		do_reset(2'h2);
		rchk(8'h04, 32'h0049_2492, "pull-up codes");
		rchk(8'h00, 32'hFF, "pull-up data");
		rchk(8'h10, 32'h4, "stored cfg");
		$display("test reset config done");
		give_verdict();
	end
endmodule
